// ==== adc_pkg.sv ====
// Shared constants for the two-wire converter interface and its controller
package adc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_FMAX_KHZ  = 3400;
  // Half SCL period, rounded up so the clock never exceeds 3.4 MHz
  localparam logic [7:0] SCL_HALF_CYC = 8'((1_000_000
    + 2 * SCL_FMAX_KHZ * CLK_PERIOD_NS - 1)
    / (2 * SCL_FMAX_KHZ * CLK_PERIOD_NS));
  // Data changes mid-way through SCL low, away from both edges
  localparam logic [7:0] SCL_SET_AT   = SCL_HALF_CYC >> 1;
  localparam int TBUF_NS = 1300;
  localparam logic [7:0] TBUF_CYC     = 8'((TBUF_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS);
  // Device type code: arbitrary value
  localparam logic [4:0] DEV_TYPE     = 5'h0b;
  localparam int RES_STEPS = 1024;
  localparam int RES_W     = $clog2(RES_STEPS);
  localparam logic [RES_W-1:0] SAR_MSB = RES_W'(RES_STEPS / 2);
  localparam logic [3:0] SAR_LAST     = 4'h9;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [2:0] OSC_DIV      = 3'h4;
  localparam logic [1:0] STRAP_CNT    = 2'h2;
  // Command byte field positions
  localparam int CMD_SE_BIT = 7;
  localparam int CMD_CH_LSB = 4;
  localparam int CMD_PD_LSB = 2;
  localparam int PD_CONV_BIT = 0;
  localparam int PD_REF_BIT  = 1;
  localparam logic [1:0] PD_RST       = 2'h0;
  // Controller register map
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_CFG      = 4'h4;
  localparam logic [3:0] REG_STAT     = 4'h8;
  localparam logic [3:0] REG_DATA     = 4'hc;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam logic [9:0] CFG_RST      = 10'h000;
endpackage

// ==== adc_i2c_if.sv ====
// Two-wire bus joining the controller and the converter interface
`timescale 1ns/1ps
`default_nettype none
interface adc_i2c_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open-drain wired-AND with pull-ups
  assign scl = (scl_m_oe && !scl_m_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o)) ? 1'b0
               : 1'b1;
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (output scl_m_o, output scl_m_oe, output sda_m_o,
                output sda_m_oe, input scl, input sda);
endinterface
`default_nettype wire

// ==== adc_pin_filt.sv ====
// Pin synchroniser with single-sample spike rejection
`timescale 1ns/1ps
`default_nettype none
module adc_pin_filt
  import adc_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r  <= 1'b1;
      sync_r  <= 1'b1;
      prev_r  <= 1'b1;
      level_o <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
      // Two equal samples needed, so a lone spike never passes
      if (sync_r == prev_r) begin
        level_o <= prev_r;
      end
    end
  end
endmodule // adc_pin_filt
`default_nettype wire

// ==== adc_dev_end.sv ====
// Converter end: two-wire slave, command decode and conversion core
`timescale 1ns/1ps
`default_nettype none
module adc_dev_end
  import adc_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic             addr_select_hi_pin_i,
  input  wire logic             addr_select_lo_pin_i,
  input  wire logic [RES_W-1:0] analog_code_i,
  output logic                  core_on_o,
  output logic                  osc_on_o,
  output logic                  ref_on_o,
  output logic                  single_ended_select_o,
  output logic [2:0]            channel_field_o,
  output logic                  busy_o,
  output logic [RES_W-1:0]      result_o,
  adc_i2c_if.dev                bus
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RX    = 3'b001,
    S_ACK   = 3'b010,
    S_TX    = 3'b011,
    S_TXACK = 3'b100
  } adc_dev_st_t;

  adc_dev_st_t      st_r;
  logic             scl_f;
  logic             sda_f;
  logic             scl_q_r;
  logic             sda_q_r;
  logic [3:0]       cnt_r;
  logic [7:0]       rx_sh_r;
  logic [7:0]       tx_sh_r;
  logic             first_r;
  logic             rw_r;
  logic             bsel_r;
  logic [1:0]       sel_meta_r;
  logic [1:0]       sel_sync_r;
  logic [1:0]       sel_r;
  logic [1:0]       strap_cnt_r;
  logic [1:0]       pd_r;
  logic [2:0]       osc_cnt_r;
  logic             osc_tick_r;
  logic [3:0]       sar_idx_r;
  logic [RES_W-1:0] trial_w;
  logic [7:0]       tx_byte_w;
  logic             start_w;
  logic             stop_w;
  logic             rise_w;
  logic             fall_w;
  logic             byte_end_w;
  logic             cmd_take_w;

  function automatic logic [7:0] res_byte(input logic             hi_half,
                                          input logic [RES_W-1:0] res);
    res_byte = hi_half ? {res[5:0], 2'b00} : {4'h0, res[9:6]};
  endfunction

  adc_pin_filt u_scl_filt (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (bus.scl),
    .level_o   (scl_f)
  );

  adc_pin_filt u_sda_filt (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (bus.sda),
    .level_o   (sda_f)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  assign start_w    = scl_f && scl_q_r && sda_q_r && !sda_f;
  assign stop_w     = scl_f && scl_q_r && !sda_q_r && sda_f;
  assign rise_w     = scl_f && !scl_q_r;
  assign fall_w     = !scl_f && scl_q_r;
  assign byte_end_w = (st_r == S_RX) && fall_w && (cnt_r == BYTE_BITS);
  assign cmd_take_w = byte_end_w && !first_r && !rw_r && !start_w && !stop_w;
  assign tx_byte_w  = res_byte(bsel_r, result_o);

  // Select straps caught once, shortly after reset release
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_meta_r  <= 2'h0;
      sel_sync_r  <= 2'h0;
      sel_r       <= 2'h0;
      strap_cnt_r <= 2'h0;
    end else begin
      sel_meta_r <= {addr_select_hi_pin_i, addr_select_lo_pin_i};
      sel_sync_r <= sel_meta_r;
      if (strap_cnt_r != 2'h3) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      if (strap_cnt_r == STRAP_CNT) begin
        sel_r <= sel_sync_r;
      end
    end
  end

  // Serial engine; SCL is only ever sampled here
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r         <= S_IDLE;
      cnt_r        <= 4'h0;
      rx_sh_r      <= 8'h00;
      tx_sh_r      <= 8'h00;
      first_r      <= 1'b0;
      rw_r         <= 1'b0;
      bsel_r       <= 1'b0;
      bus.sda_s_oe <= 1'b0;
      bus.sda_s_o  <= 1'b0;
    end else if (start_w) begin
      st_r         <= S_RX;
      cnt_r        <= 4'h0;
      first_r      <= 1'b1;
      bus.sda_s_oe <= 1'b0;
    end else if (stop_w) begin
      st_r         <= S_IDLE;
      bus.sda_s_oe <= 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
        end
        S_RX: begin
          if (rise_w) begin
            rx_sh_r <= {rx_sh_r[6:0], sda_f};
            cnt_r   <= cnt_r + 4'h1;
          end else if (byte_end_w) begin
            cnt_r <= 4'h0;
            if (first_r && rx_sh_r[7:1] != {DEV_TYPE, sel_r}) begin
              st_r <= S_IDLE;
            end else begin
              st_r         <= S_ACK;
              bus.sda_s_oe <= 1'b1;
              if (first_r) begin
                rw_r   <= rx_sh_r[0];
                bsel_r <= 1'b0;
              end
            end
          end
        end
        S_ACK: begin
          if (fall_w) begin
            first_r <= 1'b0;
            if (rw_r) begin
              st_r         <= S_TX;
              bus.sda_s_oe <= !tx_byte_w[7];
              tx_sh_r      <= {tx_byte_w[6:0], 1'b0};
              cnt_r        <= 4'h1;
              bsel_r       <= !bsel_r;
            end else begin
              st_r         <= S_RX;
              bus.sda_s_oe <= 1'b0;
            end
          end
        end
        S_TX: begin
          if (fall_w) begin
            if (cnt_r == BYTE_BITS) begin
              st_r         <= S_TXACK;
              bus.sda_s_oe <= 1'b0;
            end else begin
              bus.sda_s_oe <= !tx_sh_r[7];
              tx_sh_r      <= {tx_sh_r[6:0], 1'b0};
              cnt_r        <= cnt_r + 4'h1;
            end
          end
        end
        S_TXACK: begin
          // No-ack leaves SDA released until the master's STOP
          if (rise_w) begin
            st_r <= sda_f ? S_IDLE : S_ACK;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      single_ended_select_o <= 1'b0;
      channel_field_o       <= 3'h0;
      pd_r                  <= PD_RST;
      ref_on_o              <= 1'b0;
    end else begin
      if (cmd_take_w) begin
        single_ended_select_o <= rx_sh_r[CMD_SE_BIT];
        channel_field_o       <= rx_sh_r[CMD_CH_LSB +: 3];
        pd_r                  <= rx_sh_r[CMD_PD_LSB +: 2];
      end
      ref_on_o <= pd_r[PD_REF_BIT];
    end
  end

  // Power only while converting, from START until STOP, an address mismatch or a read no-ack, or held on by command
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_on_o  <= 1'b0;
      osc_on_o   <= 1'b0;
      osc_cnt_r  <= 3'h0;
      osc_tick_r <= 1'b0;
    end else begin
      core_on_o <= busy_o || (st_r != S_IDLE) || pd_r[PD_CONV_BIT];
      osc_on_o  <= busy_o || (st_r != S_IDLE) || pd_r[PD_CONV_BIT];
      osc_tick_r <= 1'b0;
      if (!osc_on_o) begin
        osc_cnt_r <= 3'h0;
      end else if (osc_cnt_r == OSC_DIV - 3'h1) begin
        osc_cnt_r  <= 3'h0;
        osc_tick_r <= 1'b1;
      end else begin
        osc_cnt_r <= osc_cnt_r + 3'h1;
      end
    end
  end

  assign trial_w = result_o | (SAR_MSB >> sar_idx_r);

  // Successive approximation, one bit per oscillator tick
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o    <= 1'b0;
      sar_idx_r <= 4'h0;
      result_o  <= '0;
    end else if (cmd_take_w) begin
      busy_o    <= 1'b1;
      sar_idx_r <= 4'h0;
      result_o  <= '0;
    end else if (busy_o && osc_tick_r) begin
      if (analog_code_i >= trial_w) begin
        result_o <= trial_w;
      end
      sar_idx_r <= sar_idx_r + 4'h1;
      if (sar_idx_r == SAR_LAST) begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule // adc_dev_end
`default_nettype wire

// ==== adc_host_end.sv ====
// Controller end: bus master driven from a small register port
`timescale 1ns/1ps
`default_nettype none
module adc_host_end
  import adc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  adc_i2c_if.host          bus
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_START = 3'b001,
    H_LO    = 3'b010,
    H_HI    = 3'b011,
    H_STOP  = 3'b100
  } adc_host_st_t;

  adc_host_st_t st_r;
  logic [9:0]   cfg_r;
  logic [7:0]   tmr_r;
  logic [3:0]   cnt_r;
  logic [1:0]   idx_r;
  logic         op_rd_r;
  logic         stp_r;
  logic         nack_r;
  logic [15:0]  rxd_r;
  logic         sda_meta_r;
  logic         sda_s_r;
  logic         go_w;
  logic         rx_w;
  logic         last_w;
  logic         bit_w;
  logic [7:0]   txb_w;
  logic [7:0]   txsh_w;

  // Start ignored while busy or during bus free time
  assign go_w   = wr_i && (addr_i == REG_CTRL) && wdata_i[CTRL_GO_BIT]
                  && (st_r == H_IDLE) && (tmr_r == 8'h00);
  assign rx_w   = op_rd_r && (idx_r != 2'h0);
  assign last_w = op_rd_r ? (idx_r == 2'h2) : (idx_r == 2'h1);
  assign txb_w  = (idx_r == 2'h0) ? {DEV_TYPE, cfg_r[9:8], op_rd_r}
                  : (rx_w ? 8'hff : cfg_r[7:0]);
  assign txsh_w = txb_w << cnt_r[2:0];
  // Ack own read bytes except the last
  assign bit_w  = (cnt_r != BYTE_BITS) ? txsh_w[7]
                  : (rx_w ? last_w : 1'b1);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_meta_r <= 1'b1;
      sda_s_r    <= 1'b1;
    end else begin
      sda_meta_r <= bus.sda;
      sda_s_r    <= sda_meta_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_r   <= CFG_RST;
      rdata_o <= 32'h0000_0000;
    end else begin
      if (wr_i && addr_i == REG_CFG) begin
        cfg_r <= wdata_i[9:0];
      end
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        unique case (addr_i)
          REG_CFG:  rdata_o <= {22'h0, cfg_r};
          REG_STAT: rdata_o <= {30'h0, nack_r, st_r != H_IDLE};
          REG_DATA: rdata_o <= {16'h0, rxd_r};
          default:  rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r         <= H_IDLE;
      tmr_r        <= 8'h00;
      cnt_r        <= 4'h0;
      idx_r        <= 2'h0;
      op_rd_r      <= 1'b0;
      stp_r        <= 1'b0;
      nack_r       <= 1'b0;
      rxd_r        <= 16'h0000;
      bus.scl_m_oe <= 1'b0;
      bus.scl_m_o  <= 1'b0;
      bus.sda_m_oe <= 1'b0;
      bus.sda_m_o  <= 1'b0;
    end else begin
      if (tmr_r != 8'h00) begin
        tmr_r <= tmr_r - 8'h01;
      end
      unique case (st_r)
        H_IDLE: begin
          if (go_w) begin
            st_r         <= H_START;
            bus.sda_m_oe <= 1'b1;
            tmr_r        <= SCL_HALF_CYC;
            nack_r       <= 1'b0;
            idx_r        <= 2'h0;
            op_rd_r      <= wdata_i[CTRL_RD_BIT];
          end
        end
        H_START: begin
          if (tmr_r == 8'h00) begin
            bus.scl_m_oe <= 1'b1;
            st_r         <= H_LO;
            tmr_r        <= SCL_HALF_CYC;
            cnt_r        <= 4'h0;
          end
        end
        H_LO: begin
          if (tmr_r == SCL_SET_AT) begin
            bus.sda_m_oe <= !bit_w;
          end
          if (tmr_r == 8'h00) begin
            bus.scl_m_oe <= 1'b0;
            st_r         <= H_HI;
            tmr_r        <= SCL_HALF_CYC;
          end
        end
        H_HI: begin
          if (tmr_r == 8'h00) begin
            bus.scl_m_oe <= 1'b1;
            tmr_r        <= SCL_HALF_CYC;
            if (cnt_r != BYTE_BITS) begin
              cnt_r <= cnt_r + 4'h1;
              st_r  <= H_LO;
              if (rx_w) begin
                rxd_r <= {rxd_r[14:0], sda_s_r};
              end
            end else if ((!rx_w && sda_s_r) || last_w) begin
              nack_r <= !rx_w && sda_s_r;
              st_r   <= H_STOP;
              stp_r  <= 1'b0;
            end else begin
              idx_r <= idx_r + 2'h1;
              cnt_r <= 4'h0;
              st_r  <= H_LO;
            end
          end
        end
        H_STOP: begin
          if (!stp_r && tmr_r == SCL_SET_AT) begin
            bus.sda_m_oe <= 1'b1;
          end
          if (tmr_r == 8'h00 && !stp_r) begin
            bus.scl_m_oe <= 1'b0;
            stp_r        <= 1'b1;
            tmr_r        <= SCL_HALF_CYC;
          end else if (tmr_r == 8'h00) begin
            bus.sda_m_oe <= 1'b0;
            st_r         <= H_IDLE;
            tmr_r        <= TBUF_CYC;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end
endmodule // adc_host_end
`default_nettype wire

// ==== adc_i2c_chk.sv ====
// Protocol checker watching the two-wire bus between both ends
`timescale 1ns/1ps
`default_nettype none
module adc_i2c_chk (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_r;
  logic       first_r;
  logic       rd_r;
  // Effective pull-downs; a driver with its output high does not pull
  wire logic  s_pull  = sda_s_oe & ~sda_s_o;
  wire logic  m_pull  = sda_m_oe & ~sda_m_o;
  wire logic  c_pull  = scl_m_oe & ~scl_m_o;
  wire logic  rise_w  = scl & ~scl_q;
  wire logic  fall_w  = ~scl & scl_q;
  wire logic  start_w = scl & scl_q & sda_q & ~sda;
  wire logic  stop_w  = scl & scl_q & ~sda_q & sda;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  // Idle bus reads high, so no false edge right after reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Bit slot count since START: 1..8 data, 9 acknowledge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_r   <= 4'h0;
      first_r <= 1'b0;
      rd_r    <= 1'b0;
    end else if (start_w) begin
      bit_r   <= 4'h0;
      first_r <= 1'b1;
    end else if (rise_w) begin
      bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
      if (first_r && bit_r == 4'h7) rd_r <= sda;
      if (first_r && bit_r == 4'h8) first_r <= 1'b0;
    end
  end

  a_drive_in_low: assert property ($changed(s_pull) |-> !scl)
    else $error("device SDA changed while SCL high");
  a_ack_steady: assert property (rise_w && s_pull |-> s_pull [*8])
    else $error("device released SDA during SCL high");
  a_addr_silent: assert property (first_r && bit_r < 4'h8 |-> !s_pull)
    else $error("device drove SDA during address bits");
  a_nack_release: assert property (
    rise_w && bit_r == 4'h8 && rd_r && !first_r && sda
    |-> ##16 !s_pull [*8])
    else $error("device drove SDA after no-acknowledge");
  a_stop_silent: assert property (stop_w |=> !s_pull [*8])
    else $error("device drove SDA after STOP");
  a_scl_high_min: assert property (rise_w |-> scl [*8])
    else $error("SCL high phase too short");
  a_scl_low_min: assert property (fall_w |-> !scl [*8])
    else $error("SCL low phase too short");
  a_single_driver: assert property (s_pull && scl |-> !m_pull)
    else $error("both ends pulled SDA during SCL high");
  // Only the host may open a frame; a device pull here is a false START
  a_start_by_host: assert property (start_w |-> m_pull && !s_pull)
    else $error("START not made by the host");

  c_addr_ack: cover property (rise_w && bit_r == 4'h8 && first_r && s_pull);
  c_nack: cover property (rise_w && bit_r == 4'h8 && rd_r && !first_r && sda);
  c_stop: cover property (stop_w);
endmodule // adc_i2c_chk
`default_nettype wire

// ==== tb_adc_i2c_slave_interface.sv ====
// Self-checking bench joining controller and converter ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check(32'(got), 32'(exp))
module tb_adc_i2c_slave_interface;
  import adc_pkg::*;
  logic             clk_sys_i;
  logic             arst_n_i;
  logic [3:0]       addr_i;
  logic [31:0]      wdata_i;
  logic             wr_i;
  logic             rd_i;
  logic [31:0]      rdata_o;
  logic             hi_pin;
  logic             lo_pin;
  logic [RES_W-1:0] code;
  logic             core_on_o, osc_on_o, ref_on_o, se_o, busy_o;
  logic [2:0]       ch_o;
  logic [RES_W-1:0] result_o;
  integer           seed = 32'h236d2d61;
  int               mismatches = 0;
  int               check_count = 0;
  logic [31:0]      exp_q[$];
  logic             chk_now = 1'b0, chk_d = 1'b0, rd_d = 1'b0;
  logic             scl_q = 1'b1, sda_q = 1'b1, ack_seen = 1'b1;
  logic [3:0]       wbits = 4'h9;
  logic [7:0]       wsh = 8'h00, addr_seen = 8'h00;

  adc_i2c_if bus_if ();
  adc_dev_end adc_dev_end_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .addr_select_hi_pin_i(hi_pin), .addr_select_lo_pin_i(lo_pin),
    .analog_code_i(code), .core_on_o(core_on_o), .osc_on_o(osc_on_o),
    .ref_on_o(ref_on_o), .single_ended_select_o(se_o),
    .channel_field_o(ch_o), .busy_o(busy_o), .result_o(result_o),
    .bus(bus_if));
  adc_host_end adc_host_end_inst (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .bus(bus_if));
  adc_i2c_chk adc_i2c_chk_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .scl_m_o(bus_if.scl_m_o), .scl_m_oe(bus_if.scl_m_oe),
    .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe),
    .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // Expectation is queued; the monitor compares it two cycles later
  task automatic rd_reg(input logic [3:0] a, input logic chk,
                        input logic [31:0] e, output logic [31:0] v);
    @(posedge clk_sys_i);
    if (chk) exp_q.push_back(e);
    addr_i  <= a;
    rd_i    <= 1'b1;
    chk_now <= chk;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    // Data launched by the previous edge still stands here
    @(posedge clk_sys_i);
    v = rdata_o;
  endtask

  // Start an operation, poll busy, then keep clear of the bus-free time
  task automatic run_op(input logic [9:0] cfg, input logic rdop,
                        output logic [31:0] stat);
    int n;
    n = 0;
    wr_reg(REG_CFG, {22'h0, cfg});
    wr_reg(REG_CTRL, {30'h0, rdop, 1'b1});
    do begin
      rd_reg(REG_STAT, 1'b0, 32'h0, stat);
      n++;
    end while (stat[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      mismatches++;
      end_sim();
    end
    repeat (140) @(posedge clk_sys_i);
  endtask

  always @(posedge clk_sys_i) begin
    rd_d  <= rd_i;
    chk_d <= chk_now;
    if (rd_d && chk_d) `CHK(rdata_o, exp_q.pop_front());
  end

  // Wire monitor: address byte MSB first and its acknowledge bit
  always @(posedge clk_sys_i) begin
    scl_q <= bus_if.scl;
    sda_q <= bus_if.sda;
    if (scl_q && bus_if.scl && sda_q && !bus_if.sda) begin
      wbits <= 4'h0;
    end else if (bus_if.scl && !scl_q && wbits < 4'h9) begin
      wbits <= wbits + 4'h1;
      wsh   <= {wsh[6:0], bus_if.sda};
      if (wbits == 4'h8) begin
        ack_seen  <= bus_if.sda;
        addr_seen <= wsh;
      end
    end
  end

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    mismatches++;
    end_sim();
  end

  initial begin
    logic [31:0] v;
    logic [7:0]  cmd;
    arst_n_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    {hi_pin, lo_pin} = 2'($random(seed));
    code = RES_W'($random(seed));
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    `CHK({ref_on_o, core_on_o, osc_on_o, busy_o}, 4'h0);
    `CHK({bus_if.scl, bus_if.sda}, 2'b11);
    rd_reg(REG_CFG, 1'b1, 32'h0, v);
    rd_reg(REG_DATA, 1'b1, 32'h0, v);
    rd_reg(4'h2, 1'b1, 32'h0, v);
    for (int i = 0; i < 4; i++) begin
      cmd = 8'($random(seed));
      cmd[3:2] = 2'(i);
      code <= RES_W'($random(seed));
      run_op({hi_pin, lo_pin, cmd}, 1'b0, v);
      `CHK(v[1:0], 2'b00);
      `CHK(addr_seen, {DEV_TYPE, hi_pin, lo_pin, 1'b0});
      `CHK(ack_seen, 1'b0);
      `CHK({se_o, ch_o}, cmd[7:4]);
      `CHK(ref_on_o, cmd[3]);
      `CHK({core_on_o, osc_on_o, busy_o}, {{2{cmd[2]}}, 1'b0});
      `CHK(result_o, code);
      run_op({hi_pin, lo_pin, cmd}, 1'b1, v);
      `CHK(v[1:0], 2'b00);
      `CHK(addr_seen, {DEV_TYPE, hi_pin, lo_pin, 1'b1});
      `CHK({bus_if.scl, bus_if.sda}, 2'b11);
      rd_reg(REG_DATA, 1'b1, {16'h0, 4'h0, code, 2'b00}, v);
    end
    run_op({~hi_pin, lo_pin, cmd}, 1'b0, v);
    `CHK(v[1:0], 2'b10);
    `CHK(ack_seen, 1'b1);
    `CHK(result_o, code);
    end_sim();
  end
endmodule // tb_adc_i2c_slave_interface
`default_nettype wire
